// ---- did_decoder.v ----
// Purpose: instruction fetch decode and operand address generation
// Assumes: memory answers each read with a one-cycle ack, data MSD high
// Notes: addresses are binary digit addresses, one level of indirection
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "did_regs.vh"

module did_decoder #(
  parameter AW = 21,
  parameter [20:0] IX_BASE = 21'h00_0008,
  parameter [6:0] BR_LO = 7'h14,
  parameter [6:0] BR_HI = 7'h1d
) (
  // clock and reset
  input wire i_clk,
  input wire i_rst_b,
  // register port
  input wire [7:0] i_reg_addr,
  input wire [31:0] i_reg_wdata,
  input wire i_reg_wr,
  input wire i_reg_rd,
  output reg [31:0] o_reg_rdata,
  // core memory read port
  output reg [AW-1:0] o_mem_addr,
  output reg o_mem_rd,
  input wire [31:0] i_mem_rdata,
  input wire i_mem_ack,
  // address memory write port
  output reg o_am_wr,
  output reg [1:0] o_am_slot,
  output reg [AW-1:0] o_am_addr,
  output reg [1:0] o_am_fmt,
  // sequencer start
  output reg o_seq_start,
  output reg [6:0] o_seq_op,
  output reg [6:0] o_seq_len_a,
  output reg [6:0] o_seq_len_b,
  // interrupt pulses and state
  output reg o_irq_invalid_op,
  output reg o_irq_odd_indirect,
  output reg o_busy
);

  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_WAIT = 4'h1;
  localparam [3:0] S_DEC = 4'h2;
  localparam [3:0] S_LENS = 4'h3;
  localparam [3:0] S_NEXT = 4'h4;
  localparam [3:0] S_ADR = 4'h5;
  localparam [3:0] S_IND = 4'h6;
  localparam [3:0] S_EMIT = 4'h7;
  localparam [3:0] S_DONE = 4'h8;

  localparam [2:0] P_OP = 3'h0;
  localparam [2:0] P_LEN = 3'h1;
  localparam [2:0] P_SYL = 3'h2;
  localparam [2:0] P_IX = 3'h3;
  localparam [2:0] P_IND = 3'h4;

  reg [3:0] state_reg;
  reg [2:0] phase_reg;
  reg [11:0] base_reg;
  reg [20:0] pc_reg;
  reg [31:0] first_reg;
  reg [6:0] op_reg;
  reg [6:0] len_a_reg;
  reg [6:0] len_b_reg;
  reg [1:0] lind_reg;
  reg lit_reg;
  reg [1:0] lit_fmt_reg;
  reg [23:0] lit_val_reg;
  reg fmtb_reg;
  reg [1:0] syl_cnt_reg;
  reg [1:0] syl_idx_reg;
  reg [3:0] ctl_reg;
  reg [20:0] acc_reg;
  reg flag_inv_reg;
  reg flag_odd_reg;
  reg flag_done_reg;

  // decimal fields turned binary
  wire [6:0] op_bin;
  wire [6:0] la_bin;
  wire [6:0] lb_bin;
  wire [9:0] base_bin;
  wire [6:0] mlen_bin;
  wire [16:0] m5_bin;
  wire [19:0] mag_bin;
  wire [19:0] m6_bin;

  did_digits #(.N(2), .W(7)) u_op (.i_digits(first_reg[31:24]), .o_value(op_bin));
  did_digits #(.N(2), .W(7)) u_la (.i_digits(first_reg[23:16]), .o_value(la_bin));
  did_digits #(.N(2), .W(7)) u_lb (.i_digits(first_reg[15:8]), .o_value(lb_bin));
  did_digits #(.N(3), .W(10)) u_base (.i_digits(base_reg), .o_value(base_bin));
  did_digits #(.N(2), .W(7)) u_mlen (.i_digits(i_mem_rdata[31:24]), .o_value(mlen_bin));
  did_digits #(.N(5), .W(17)) u_m5 (.i_digits(i_mem_rdata[27:8]), .o_value(m5_bin));
  did_digits #(.N(6), .W(20)) u_mag (.i_digits(i_mem_rdata[23:0]), .o_value(mag_bin));
  did_digits #(.N(6), .W(20)) u_m6 (.i_digits(i_mem_rdata[31:8]), .o_value(m6_bin));

  // base register as a digit address, in units of one thousand digits
  wire [20:0] base_abs = {11'h000, base_bin} * 21'h00_03e8;
  wire [20:0] pc_abs = base_abs + pc_reg;

  // assigned opcodes: {valid, format b, address syllable count}
  function [3:0] op_info;
    input [6:0] op;
    begin
      case (op)
        7'h01, 7'h03, 7'h0a, 7'h0b, 7'h0c, 7'h0d, 7'h0e: op_info = 4'b1010;
        7'h02, 7'h04, 7'h05, 7'h09: op_info = 4'b1011;
        default: op_info = (op >= BR_LO && op <= BR_HI) ? 4'b1101 : 4'b0000;
      endcase
    end
  endfunction

  wire [3:0] info = op_info(op_bin);
  wire [3:0] d3 = first_reg[23:20];
  wire [3:0] d4 = first_reg[19:16];
  wire [3:0] d5 = first_reg[15:12];
  wire [3:0] d6 = first_reg[11:8];
  wire is_lit = d3[3] & ~d3[2] & d3[1];
  wire [1:0] lfmt = {d3[0], d4[3]};
  wire [2:0] llen = d4[2:0];

  // literal length ceiling per literal format
  reg [2:0] lmax;
  always @* begin
    case (lfmt)
      2'h0: lmax = 3'h6;
      2'h1: lmax = 3'h5;
      2'h2: lmax = 3'h3;
      default: lmax = 3'h0;
    endcase
  end
  wire lit_bad = is_lit & ((llen == 3'h0) | (llen > lmax));

  // indirect length location: low bits of lead digit, even next digit
  wire [20:0] lenloc_a = {19'h0_0000, d3[1:0]} * 21'h00_000a + {17'h0_0000, d4[3:1], 1'b0};
  wire [20:0] lenloc_b = {19'h0_0000, d5[1:0]} * 21'h00_000a + {17'h0_0000, d6[3:1], 1'b0};

  // operand address of the syllable in hand
  wire [1:0] m_fmt = i_mem_rdata[29:28];
  wire [20:0] m_ext = (fmtb_reg && m_fmt != `DID_FMT_INDIRECT) ?
                      {19'h0_0000, m_fmt} * 21'h01_86a0 : 21'h00_0000;
  wire [20:0] m_rel = m_ext + {4'h0, m5_bin};
  wire [20:0] syl_ofs = fmtb_reg ? 21'h00_0002 :
                        `DID_SYL_DIGITS * {19'h0_0000, syl_idx_reg + 2'h1};
  wire [20:0] ix_loc = base_abs + IX_BASE +
                       `DID_IXREG_DIGITS * {19'h0_0000, ctl_reg[3:2] - 2'h1};
  // three address syllables make four in all, so the count needs a third bit
  wire [20:0] ilen = fmtb_reg ? `DID_FMTB_DIGITS :
                     `DID_SYL_DIGITS * {18'h0_0000, {1'b0, syl_cnt_reg} + 3'h1};

  wire wr_ctrl = i_reg_wr && i_reg_addr == `DID_CTRL_OFS;
  wire start = wr_ctrl && i_reg_wdata[`DID_CTRL_START] && state_reg == S_IDLE;
  wire clr = wr_ctrl && i_reg_wdata[`DID_CTRL_CLR];

  // fetch sequencer, also owns the software-visible registers
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg <= S_IDLE;
      phase_reg <= P_OP;
      base_reg <= `DID_BASE_RST;
      pc_reg <= `DID_PC_RST;
      first_reg <= 32'h0000_0000;
      op_reg <= 7'h00;
      len_a_reg <= 7'h00;
      len_b_reg <= 7'h00;
      lind_reg <= 2'h0;
      lit_reg <= 1'b0;
      lit_fmt_reg <= 2'h0;
      lit_val_reg <= 24'h00_0000;
      fmtb_reg <= 1'b0;
      syl_cnt_reg <= 2'h0;
      syl_idx_reg <= 2'h0;
      ctl_reg <= 4'h0;
      acc_reg <= 21'h00_0000;
      flag_inv_reg <= 1'b0;
      flag_odd_reg <= 1'b0;
      flag_done_reg <= 1'b0;
      o_mem_addr <= {AW{1'b0}};
      o_mem_rd <= 1'b0;
      o_am_wr <= 1'b0;
      o_am_slot <= 2'h0;
      o_am_addr <= {AW{1'b0}};
      o_am_fmt <= 2'h0;
      o_seq_start <= 1'b0;
      o_seq_op <= 7'h00;
      o_seq_len_a <= 7'h00;
      o_seq_len_b <= 7'h00;
      o_irq_invalid_op <= 1'b0;
      o_irq_odd_indirect <= 1'b0;
      o_busy <= 1'b0;
    end else begin
      o_mem_rd <= 1'b0;
      o_am_wr <= 1'b0;
      o_seq_start <= 1'b0;
      o_irq_invalid_op <= 1'b0;
      o_irq_odd_indirect <= 1'b0;
      // clear comes first so a same-cycle set below wins
      if (clr) begin
        flag_inv_reg <= 1'b0;
        flag_odd_reg <= 1'b0;
        flag_done_reg <= 1'b0;
      end
      // register writes to base and pc land only while idle, a fetch needs them stable
      if (i_reg_wr && state_reg == S_IDLE) begin
        if (i_reg_addr == `DID_BASE_OFS) begin
          base_reg <= i_reg_wdata[11:0];
        end
        if (i_reg_addr == `DID_PC_OFS) begin
          pc_reg <= i_reg_wdata[20:0];
        end
      end
      case (state_reg)
        S_IDLE: begin
          if (start) begin
            o_busy <= 1'b1;
            o_mem_rd <= 1'b1;
            o_mem_addr <= pc_abs[AW-1:0];
            phase_reg <= P_OP;
            state_reg <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (i_mem_ack) begin
            case (phase_reg)
              P_OP: begin
                first_reg <= i_mem_rdata;
                state_reg <= S_DEC;
              end
              P_LEN: begin
                if (lind_reg[0]) begin
                  len_a_reg <= (mlen_bin == 7'h00) ? 7'h64 : mlen_bin;
                  lind_reg[0] <= 1'b0;
                end else begin
                  len_b_reg <= (mlen_bin == 7'h00) ? 7'h64 : mlen_bin;
                  lind_reg[1] <= 1'b0;
                end
                state_reg <= S_LENS;
              end
              P_SYL: begin
                if (lit_reg && syl_idx_reg == 2'h0) begin
                  lit_val_reg <= i_mem_rdata[31:8];
                  syl_idx_reg <= syl_idx_reg + 2'h1;
                  state_reg <= S_NEXT;
                end else begin
                  ctl_reg <= i_mem_rdata[31:28];
                  acc_reg <= base_abs + m_rel;
                  state_reg <= S_ADR;
                end
              end
              P_IX: begin
                if (i_mem_rdata[31:28] == `DID_MINUS) begin
                  acc_reg <= acc_reg - {1'b0, mag_bin};
                end else begin
                  acc_reg <= acc_reg + {1'b0, mag_bin};
                end
                state_reg <= S_IND;
              end
              default: begin
                acc_reg <= base_abs + {1'b0, m6_bin};
                state_reg <= S_EMIT;
              end
            endcase
          end
        end
        S_DEC: begin
          op_reg <= op_bin;
          fmtb_reg <= info[2];
          syl_cnt_reg <= info[1:0];
          syl_idx_reg <= 2'h0;
          lit_reg <= is_lit & ~info[2];
          lit_fmt_reg <= lfmt;
          lit_val_reg <= 24'h00_0000;
          len_a_reg <= is_lit ? {4'h0, llen} : ((la_bin == 7'h00) ? 7'h64 : la_bin);
          len_b_reg <= (lb_bin == 7'h00) ? 7'h64 : lb_bin;
          lind_reg <= {d5[3:2] == 2'h3, d3[3:2] == 2'h3} & {2{~info[2]}};
          if (!info[3] || (lit_bad && !info[2])) begin
            flag_inv_reg <= 1'b1;
            o_irq_invalid_op <= 1'b1;
            state_reg <= S_DONE;
          end else begin
            state_reg <= S_LENS;
          end
        end
        S_LENS: begin
          if (lind_reg[0]) begin
            o_mem_rd <= 1'b1;
            o_mem_addr <= (base_abs + lenloc_a) & {AW{1'b1}};
            phase_reg <= P_LEN;
            state_reg <= S_WAIT;
          end else if (lind_reg[1]) begin
            o_mem_rd <= 1'b1;
            o_mem_addr <= (base_abs + lenloc_b) & {AW{1'b1}};
            phase_reg <= P_LEN;
            state_reg <= S_WAIT;
          end else begin
            state_reg <= S_NEXT;
          end
        end
        S_NEXT: begin
          if (syl_idx_reg == syl_cnt_reg) begin
            state_reg <= S_DONE;
          end else begin
            o_mem_rd <= 1'b1;
            o_mem_addr <= (pc_abs + syl_ofs) & {AW{1'b1}};
            phase_reg <= P_SYL;
            state_reg <= S_WAIT;
          end
        end
        S_ADR: begin
          if (ctl_reg[3:2] != 2'h0) begin
            o_mem_rd <= 1'b1;
            o_mem_addr <= ix_loc[AW-1:0];
            phase_reg <= P_IX;
            state_reg <= S_WAIT;
          end else begin
            state_reg <= S_IND;
          end
        end
        S_IND: begin
          if (ctl_reg[1:0] != `DID_FMT_INDIRECT) begin
            state_reg <= S_EMIT;
          end else if (acc_reg[0]) begin
            flag_odd_reg <= 1'b1;
            o_irq_odd_indirect <= 1'b1;
            state_reg <= S_DONE;
          end else begin
            o_mem_rd <= 1'b1;
            o_mem_addr <= acc_reg[AW-1:0];
            phase_reg <= P_IND;
            state_reg <= S_WAIT;
          end
        end
        S_EMIT: begin
          o_am_wr <= 1'b1;
          o_am_slot <= syl_idx_reg;
          o_am_addr <= acc_reg[AW-1:0];
          o_am_fmt <= ctl_reg[1:0];
          syl_idx_reg <= syl_idx_reg + 2'h1;
          state_reg <= S_NEXT;
        end
        S_DONE: begin
          // an aborted fetch leaves pc on the faulty instruction
          if (!flag_inv_reg && !flag_odd_reg) begin
            o_seq_start <= 1'b1;
            o_seq_op <= op_reg;
            o_seq_len_a <= len_a_reg;
            o_seq_len_b <= len_b_reg;
            pc_reg <= pc_reg + ilen;
          end
          flag_done_reg <= 1'b1;
          o_busy <= 1'b0;
          state_reg <= S_IDLE;
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  // read mux, data only in the cycle after the strobe
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_reg_rdata <= 32'h0000_0000;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        `DID_BASE_OFS: o_reg_rdata <= {20'h0_0000, base_reg};
        `DID_PC_OFS: o_reg_rdata <= {11'h000, pc_reg};
        `DID_STAT_OFS: o_reg_rdata <= {28'h000_0000, flag_done_reg, flag_odd_reg,
                                       flag_inv_reg, o_busy};
        `DID_DEC_OFS: o_reg_rdata <= {5'h00, lit_reg, lit_fmt_reg, 1'b0, len_b_reg,
                                      1'b0, len_a_reg, 1'b0, op_reg};
        `DID_LIT_OFS: o_reg_rdata <= {8'h00, lit_val_reg};
        default: o_reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      o_reg_rdata <= 32'h0000_0000;
    end
  end

endmodule // did_decoder

`default_nettype wire

// ---- did_decoder_asserts.sv ----
// Purpose: port checks of the decoder
// Assumes: one clock, async active-low reset
// Notes: ties pulses and states to their causes
`timescale 1ns/100ps
`default_nettype none
module did_decoder_asserts (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // memory port
  input wire logic o_mem_rd,
  input wire logic i_mem_ack,
  // address memory and sequencer
  input wire logic o_am_wr,
  input wire logic [1:0] o_am_slot,
  input wire logic o_seq_start,
  input wire logic [6:0] o_seq_op,
  input wire logic [6:0] o_seq_len_a,
  input wire logic [6:0] o_seq_len_b,
  // interrupts and state
  input wire logic o_irq_invalid_op,
  input wire logic o_irq_odd_indirect,
  input wire logic o_busy
);
  logic pend_reg;
  // a read is open from request until its ack
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) pend_reg <= 1'b0;
    else if (o_mem_rd) pend_reg <= 1'b1;
    else if (i_mem_ack) pend_reg <= 1'b0;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  a_mem_one_open: assert property (o_mem_rd |-> !pend_reg && !i_mem_ack)
    else $error("second memory read while one is open");
  a_mem_rd_pulse: assert property (o_mem_rd |=> !o_mem_rd)
    else $error("memory read longer than one cycle");
  a_fetch_busy: assert property (o_mem_rd |-> o_busy)
    else $error("memory read outside a fetch");
  a_start_clean: assert property (o_seq_start |-> !o_busy && $past(o_busy) &&
    !o_irq_invalid_op && !o_irq_odd_indirect)
    else $error("start without a clean finished fetch");
  a_op_decimal: assert property (o_seq_start |-> o_seq_op <= 7'h63)
    else $error("started operator above 99");
  a_lena_range: assert property (o_seq_start |-> o_seq_len_a inside {[7'h01:7'h64]})
    else $error("first length outside 1 to 100");
  a_lenb_range: assert property (o_seq_start |-> o_seq_len_b inside {[7'h01:7'h64]})
    else $error("second length outside 1 to 100");
  a_am_slot: assert property (o_am_wr |-> o_am_slot <= 2'h2 && (o_busy || $past(o_busy)))
    else $error("address memory write to a bad slot");
  a_odd_abort: assert property (o_irq_odd_indirect |=> !o_irq_odd_indirect && !o_seq_start)
    else $error("odd indirect did not abort");
  a_inv_end: assert property (o_irq_invalid_op |=> !o_irq_invalid_op && !o_busy)
    else $error("invalid operator did not end the fetch");
  c_start: cover property (o_seq_start);
  c_invalid: cover property (o_irq_invalid_op);
  c_odd: cover property (o_irq_odd_indirect);
  c_slot_b: cover property (o_am_wr && o_am_slot == 2'h1);
endmodule // did_decoder_asserts
bind did_decoder did_decoder_asserts u_chk (
  .i_clk(i_clk), .i_rst_b(i_rst_b), .o_mem_rd(o_mem_rd), .i_mem_ack(i_mem_ack),
  .o_am_wr(o_am_wr), .o_am_slot(o_am_slot), .o_seq_start(o_seq_start),
  .o_seq_op(o_seq_op), .o_seq_len_a(o_seq_len_a), .o_seq_len_b(o_seq_len_b),
  .o_irq_invalid_op(o_irq_invalid_op), .o_irq_odd_indirect(o_irq_odd_indirect),
  .o_busy(o_busy));
`default_nettype wire

// ---- did_decoder_tb.sv ----
// Purpose: self-checking bench of the decoder
// Assumes: base 2, so programs sit at digit 2000
// Notes: index registers at 2008, 2016, 2024
`timescale 1ns/100ps
`default_nettype none
`include "did_regs.vh"
module did_decoder_tb;
  logic clk, rst_b, wr, rd, mrd, ack, amw, st, inv, odd, busy;
  logic [7:0] ra;
  logic [31:0] wd, rdat, md, d;
  logic [20:0] ma, aa, ma0;
  logic [1:0] sl, fm;
  logic [6:0] op, la, lb;
  logic [2:0] lat;
  logic [24:0] amq[$];
  int n_fail, checked, nst, ninv, nodd, nrd;
  did_decoder dut (.i_clk(clk), .i_rst_b(rst_b), .i_reg_addr(ra), .i_reg_wdata(wd),
    .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdat), .o_mem_addr(ma), .o_mem_rd(mrd),
    .i_mem_rdata(md), .i_mem_ack(ack), .o_am_wr(amw), .o_am_slot(sl), .o_am_addr(aa),
    .o_am_fmt(fm), .o_seq_start(st), .o_seq_op(op), .o_seq_len_a(la), .o_seq_len_b(lb),
    .o_irq_invalid_op(inv), .o_irq_odd_indirect(odd), .o_busy(busy));
  did_mem_model mem (.i_clk(clk), .i_rst_b(rst_b), .i_mem_addr(ma), .i_mem_rd(mrd),
    .i_lat(lat), .o_mem_rdata(md), .o_mem_ack(ack));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // collect address memory writes and event pulses
  always @(posedge clk) begin
    if (amw === 1'b1) amq.push_back({sl, fm, aa});
    if (st === 1'b1) nst++;
    if (inv === 1'b1) ninv++;
    if (odd === 1'b1) nodd++;
    if (mrd === 1'b1) begin
      if (nrd == 0) ma0 = ma;
      nrd++;
    end
  end
  task end_of_test;
    if (n_fail == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task chkam(input int i, input logic [1:0] s, input logic [1:0] f, input logic [20:0] a);
    chk("am entry", {7'h00, s, f, a}, {7'h00, amq[i]});
  endtask
  task wrr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    wr <= 1'b1; ra <= a; wd <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task rdr(input logic [7:0] a);
    @(posedge clk);
    rd <= 1'b1; ra <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdat;
  endtask
  task run(input logic [20:0] pc, input logic [2:0] l);
    int k;
    amq.delete();
    nst = 0; ninv = 0; nodd = 0; nrd = 0;
    lat <= l;
    wrr(`DID_PC_OFS, {11'h000, pc});
    wrr(`DID_CTRL_OFS, 32'h0000_0003);
    repeat (2) @(posedge clk);
    #1 chk("busy", 32'h0000_0001, {31'h0, busy});
    k = 0;
    while (busy !== 1'b0 && k < 400) begin
      @(posedge clk);
      k++;
    end
    repeat (3) @(posedge clk);
    #1 chk("idle", 32'h0000_0000, {31'h0, busy});
  endtask
  task t_regs;
    rdr(`DID_STAT_OFS); chk("status", 32'h0000_0000, d);
    rdr(`DID_PC_OFS); chk("pc", 32'h0000_0000, d);
    rdr(8'h20); chk("unmapped", 32'h0000_0000, d);
    wrr(`DID_BASE_OFS, 32'h0000_0002);
    rdr(`DID_BASE_OFS); chk("base", 32'h0000_0002, d);
  endtask
  // two addresses, second indexed with a minus sign, length 00
  task t_two;
    mem.put(2100, 24'h10_0500); mem.put(2106, 24'h00_0123); mem.put(2112, 24'h90_0500);
    mem.put8(2016, 32'hd000_0045);
    run(21'h00_0064, 3'h0);
    chk("am count", 32'h0000_0002, amq.size());
    chkam(0, 2'h0, 2'h0, 21'h00_084b);
    chkam(1, 2'h1, 2'h1, 21'h00_0997);
    chk("op", 32'h0000_000a, {25'h0, op});
    chk("len a", 32'h0000_0005, {25'h0, la});
    chk("len b", 32'h0000_0064, {25'h0, lb});
    chk("starts", 32'h0000_0001, nst);
    chk("mem reads", 32'h0000_0004, nrd);
    chk("fetch addr", 32'h0000_0834, {11'h000, ma0});
    rdr(`DID_PC_OFS); chk("pc", 32'h0000_0076, d);
  endtask
  // eight-digit form, format value 2 extends the address
  task t_fmt_b;
    mem.put8(2200, 32'h2020_0007);
    run(21'h00_00c8, 3'h3);
    chk("am count", 32'h0000_0001, amq.size());
    chkam(0, 2'h0, 2'h2, 21'h03_1517);
    rdr(`DID_PC_OFS); chk("pc", 32'h0000_00d0, d);
  endtask
  task t_invalid;
    mem.put(2300, 24'h99_0000);
    run(21'h00_012c, 3'h1);
    chk("inv irq", 32'h0000_0001, ninv);
    chk("starts", 32'h0000_0000, nst);
    rdr(`DID_STAT_OFS); chk("inv flag", 32'h0000_0001, {31'h0, d[1]});
    rdr(`DID_PC_OFS); chk("pc", 32'h0000_012c, d);
  endtask
  // indirect length, even indirect A, odd indirect B after indexing
  task t_indirect;
    mem.put(2400, 24'h01_c405); mem.put(2004, 24'h07_0000);
    mem.put(2406, 24'h30_0040); mem.put(2040, 24'h00_0300);
    mem.put(2412, 24'h70_0030); mem.put8(2008, 32'h0000_0001);
    run(21'h00_0190, 3'h2);
    chk("am count", 32'h0000_0001, amq.size());
    chkam(0, 2'h0, 2'h3, 21'h00_08fc);
    chk("odd irq", 32'h0000_0001, nodd);
    chk("mem reads", 32'h0000_0006, nrd);
    chk("starts", 32'h0000_0000, nst);
    rdr(`DID_DEC_OFS); chk("len a", 32'h0000_0007, {25'h0, d[14:8]});
  endtask
  // three-digit literal, then one too long for signed format
  task t_literal;
    mem.put(2500, 24'h10_a305); mem.put(2506, 24'h12_3000); mem.put(2512, 24'h00_0200);
    run(21'h00_01f4, 3'h0);
    chk("am count", 32'h0000_0001, amq.size());
    chkam(0, 2'h1, 2'h0, 21'h00_0898);
    chk("len a", 32'h0000_0003, {25'h0, la});
    rdr(`DID_LIT_OFS); chk("literal", 32'h0012_3000, d);
    rdr(`DID_DEC_OFS); chk("lit flag", 32'h0000_0001, {31'h0, d[26]});
    mem.put(2600, 24'h10_af05); mem.put(2606, 24'h12_3450); mem.put(2612, 24'h00_0200);
    run(21'h00_0258, 3'h1);
    chk("inv irq", 32'h0000_0001, ninv);
  endtask
  // three addresses, format 2 not extended in the six-digit form
  task t_three;
    mem.put(2700, 24'h02_0000); mem.put(2706, 24'h00_0001);
    mem.put(2712, 24'h20_0002); mem.put(2718, 24'h10_0003);
    run(21'h00_02bc, 3'h1);
    chk("am count", 32'h0000_0003, amq.size());
    chkam(1, 2'h1, 2'h2, 21'h00_07d2);
    chkam(2, 2'h2, 2'h1, 21'h00_07d3);
    chk("fetch addr", 32'h0000_0a8c, {11'h000, ma0});
    rdr(`DID_PC_OFS); chk("pc", 32'h0000_02d4, d);
  endtask
  // reset in mid-fetch: fetch dropped, registers back to reset values
  task t_reset;
    wrr(`DID_PC_OFS, 32'h0000_0064);
    wrr(`DID_CTRL_OFS, 32'h0000_0001);
    repeat (3) @(posedge clk);
    rst_b <= 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    #1 chk("busy", 32'h0000_0000, {31'h0, busy});
    rdr(`DID_PC_OFS); chk("pc", 32'h0000_0000, d);
    rdr(`DID_BASE_OFS); chk("base", 32'h0000_0000, d);
    run(21'h00_0000, 3'h0);
    chk("inv irq", 32'h0000_0001, ninv);
  endtask
  initial begin
    rst_b = 1'b0; wr = 1'b0; rd = 1'b0; ra = 8'h00; wd = 32'h0000_0000; lat = 3'h0;
    n_fail = 0; checked = 0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_two();
    t_fmt_b();
    t_invalid();
    t_indirect();
    t_literal();
    t_three();
    t_reset();
    end_of_test();
  end
  // cut a hang short
  initial begin
    #60000;
    n_fail++;
    end_of_test();
  end
endmodule // did_decoder_tb
`default_nettype wire

// ---- did_digits.v ----
// Purpose: decimal digit group to binary value
// Assumes: digits are 8-4-2-1 coded, most significant digit highest
// Notes: purely combinational, instantiated once per digit field
`timescale 1ns/100ps
`default_nettype none

module did_digits #(
  parameter N = 2,
  parameter W = 7
) (
  // digit field in
  input wire [4*N-1:0] i_digits,
  // binary value out
  output reg [W-1:0] o_value
);

  localparam [W-1:0] TEN = 10;
  integer k;

  // horner chain, each digit taken at its face value
  always @* begin
    o_value = {W{1'b0}};
    for (k = N - 1; k >= 0; k = k - 1) begin
      o_value = o_value * TEN + {{(W-4){1'b0}}, i_digits[4*k +: 4]};
    end
  end

endmodule // did_digits

`default_nettype wire

// ---- did_mem_model.sv ----
// Purpose: core memory model on the far side of the decoder
// Assumes: one read outstanding, latency set by the bench
// Notes: data lines toggle when no answer is given
`timescale 1ns/100ps
`default_nettype none
module did_mem_model (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // read port
  input wire logic [20:0] i_mem_addr,
  input wire logic i_mem_rd,
  input wire logic [2:0] i_lat,
  output logic [31:0] o_mem_rdata,
  output logic o_mem_ack
);
  logic [3:0] dig [0:4095];
  logic [20:0] a_reg;
  logic [2:0] cnt_reg;
  logic pend_reg;
  // digits stored 8-4-2-1, one per address
  task put(input int a, input logic [23:0] v);
    for (int i = 0; i < 6; i++) dig[a+i] = v[23-4*i -: 4];
  endtask
  task put8(input int a, input logic [31:0] v);
    for (int i = 0; i < 8; i++) dig[a+i] = v[31-4*i -: 4];
  endtask
  initial for (int i = 0; i < 4096; i++) dig[i] = 4'h0;
  // answer after i_lat idle cycles; stale data inverted every cycle
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pend_reg <= 1'b0;
      o_mem_ack <= 1'b0;
      o_mem_rdata <= 32'h0000_0000;
    end else begin
      o_mem_ack <= 1'b0;
      o_mem_rdata <= ~o_mem_rdata;
      if (i_mem_rd) begin
        pend_reg <= 1'b1;
        cnt_reg <= i_lat;
        a_reg <= i_mem_addr;
      end else if (pend_reg && cnt_reg == 3'h0) begin
        pend_reg <= 1'b0;
        o_mem_ack <= 1'b1;
        for (int i = 0; i < 8; i++) o_mem_rdata[31-4*i -: 4] <= dig[a_reg[11:0]+i];
      end else if (pend_reg) begin
        cnt_reg <= cnt_reg - 3'h1;
      end
    end
  end
endmodule // did_mem_model
`default_nettype wire

// ---- did_placeholder_unused.v ----
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// ---- did_regs.vh ----
// Purpose: constants of the decimal instruction decoder
// Assumes: included by bare name from the decoder files
// Notes: offsets are byte addresses on the plain register port
`ifndef DID_REGS_VH
`define DID_REGS_VH

// register offsets
`define DID_CTRL_OFS 8'h00
`define DID_BASE_OFS 8'h04
`define DID_PC_OFS 8'h08
`define DID_STAT_OFS 8'h0c
`define DID_DEC_OFS 8'h10
`define DID_LIT_OFS 8'h14

// control bits
`define DID_CTRL_START 0
`define DID_CTRL_CLR 1

// status bits
`define DID_STAT_BUSY 0
`define DID_STAT_INV 1
`define DID_STAT_ODD 2
`define DID_STAT_DONE 3

// reset values
`define DID_BASE_RST 12'h000
`define DID_PC_RST 21'h00_0000

// syllable and word geometry in digits
`define DID_SYL_DIGITS 21'h00_0006
`define DID_FMTB_DIGITS 21'h00_0008
`define DID_IXREG_DIGITS 21'h00_0008

// digit codes
`define DID_MINUS 4'hd
`define DID_FMT_INDIRECT 2'h3

`endif
